// *** converter_regs_consts.vh ***
/*
  Constants of the converter configuration register bank: register
  addresses, reset values, field positions and serial frame sizes.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef CONVERTER_REGS_CONSTS_VH
`define CONVERTER_REGS_CONSTS_VH

// ----------------------------------------------------------------
// register addresses (13-bit instruction address field)
// ----------------------------------------------------------------
`define ADDR_PORT_SETUP 13'h0000
`define ADDR_PART_ID 13'h0001
`define ADDR_SPEED_GRADE 13'h0002
`define ADDR_COMMIT 13'h00FF
`define ADDR_FUNC_FIRST 13'h0008
`define ADDR_FUNC_LAST 13'h0107
`define ADDR_ANALOG_IN 13'h002C
`define ADDR_OUTPUT_MODE 13'h0014

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PORT_SETUP 8'h18
`define RST_COMMIT 8'h00
`define RST_ANALOG_IN 8'h00
`define RST_OUTPUT_MODE 8'h08
`define RST_FUNC 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_LSB_FIRST 6
`define BIT_SOFT_RESET 5
`define BIT_FIXED_HI 4
`define BIT_FIXED_LO 3
`define BIT_COMMIT 0
`define BIT_BUF_DISABLE 2
`define VARIANT_HI 6
`define VARIANT_LO 4
`define INSTR_READ 15
`define INSTR_COUNT_HI 14
`define INSTR_COUNT_LO 13

// ----------------------------------------------------------------
// frame and memory sizes
// ----------------------------------------------------------------
`define INSTR_LAST_BIT 4'hF
`define BYTE_LAST_BIT 4'h7
`define FUNC_LAST_INDEX 8'hFF

`endif

// *** conv_func_mem.v ***
/*
  Staging memory for the converter function registers, one byte per
  location, one write port and one read port with registered read data.
  Assumes a single clock; the array itself carries no reset and is
  filled with defaults by its user.
*/
`timescale 1ns/1ps
module conv_func_mem (
  input wire clk,
  input wire rst_n,
  input wire wrEn,
  input wire [7:0] wrAddr,
  input wire [7:0] wrData,
  input wire [7:0] rdAddr,
  output reg [7:0] rdData_q
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [7:0] mem [0:255];

  // write port, no reset so it maps onto plain ram
  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // read port, one cycle of latency
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= 8'h00;
    end else begin
      rdData_q <= mem[rdAddr];
    end
  end

endmodule

// *** converter_config_register_map.v ***
/*
  Configuration register bank of a high-speed converter behind a
  three-wire serial port: port setup, part identifier, speed grade,
  commit register and staged function registers.
  Assumes the serial pins are asynchronous to clk and that the serial
  clock stays high and low for at least three clk periods each.
*/
`timescale 1ns/1ps
`include "converter_regs_consts.vh"

module converter_config_register_map #(
  parameter [7:0] PART_ID = 8'hA5,     // arbitrary value
  parameter [2:0] VARIANT_CODE = 3'h5  // arbitrary value
) (
  input wire clk,
  input wire rst_n,
  input wire sclk,
  input wire chipSelectN,
  input wire sdioIn,
  output reg sdioOut_q,
  output reg sdioOutEnN_q,
  output reg [7:0] analogInputActive_q,
  output reg initBusy_q
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true for the staged function register range
  function isFunc;
    input [12:0] a;
    begin
      isFunc = (a >= `ADDR_FUNC_FIRST) && (a <= `ADDR_FUNC_LAST);
    end
  endfunction

  // memory index of a function register
  function [7:0] funcIndex;
    input [12:0] a;
    reg [12:0] d;
    begin
      d = a - `ADDR_FUNC_FIRST;
      funcIndex = d[7:0];
    end
  endfunction

  // default of a function register by memory index
  function [7:0] funcDefault;
    input [7:0] idx;
    reg [12:0] a;
    begin
      a = {5'h00, idx} + `ADDR_FUNC_FIRST;
      if (a == `ADDR_OUTPUT_MODE) begin
        funcDefault = `RST_OUTPUT_MODE;
      end else if (a == `ADDR_ANALOG_IN) begin
        funcDefault = `RST_ANALOG_IN;
      end else begin
        funcDefault = `RST_FUNC;
      end
    end
  endfunction

  function [7:0] rev8;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        rev8[i] = v[7 - i];
      end
    end
  endfunction

  function [15:0] rev16;
    input [15:0] v;
    integer i;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        rev16[i] = v[15 - i];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [2:0] pinSync1_q;
  reg [2:0] pinSync2_q;
  reg sclkPrev_q;

  // two stages before any logic; only stage two is looked at
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinSync1_q <= 3'h3;
      pinSync2_q <= 3'h3;
      sclkPrev_q <= 1'b0; // idle level, so no false edge after reset
    end else begin
      pinSync1_q <= {sclk, chipSelectN, sdioIn};
      pinSync2_q <= pinSync1_q;
      sclkPrev_q <= pinSync2_q[2];
    end
  end

  wire csHigh = pinSync2_q[1];
  wire dataBit = pinSync2_q[0];
  wire sclkRise = pinSync2_q[2] & ~sclkPrev_q;
  wire sclkFall = ~pinSync2_q[2] & sclkPrev_q;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [7:0] portSetup_q;
  reg commit_q;
  reg [7:0] analogStaged_q;
  reg [7:0] initIdx_q;
  wire lsbFirst = portSetup_q[`BIT_LSB_FIRST];

  // frame state
  reg instrPhase_q;
  reg [3:0] bitCnt_q;
  reg [15:0] shiftIn_q;
  reg isRead_q;
  reg streaming_q;
  reg [1:0] bytesLeft_q;
  reg [12:0] addr_q;
  reg [7:0] txShift_q;

  // write request handed from the frame logic to the register logic
  reg wrReq_q;
  reg [12:0] wrAddr_q;
  reg [7:0] wrData_q;

  wire [15:0] shiftNext = {shiftIn_q[14:0], dataBit};
  wire [15:0] instrWord = lsbFirst ? rev16(shiftNext) : shiftNext;
  wire [7:0] rxByte = lsbFirst ? rev8(shiftNext[7:0]) : shiftNext[7:0];
  wire [12:0] addrNext = lsbFirst ? addr_q + 13'h0001 :
                                    addr_q - 13'h0001;

  // ----------------------------------------------------------------
  // staging memory
  // ----------------------------------------------------------------
  wire memWrHost = wrReq_q && isFunc(wrAddr_q);
  wire memWe = initBusy_q | memWrHost;
  wire [7:0] memWrAddr = initBusy_q ? initIdx_q : funcIndex(wrAddr_q);
  wire [7:0] memWrData = initBusy_q ? funcDefault(initIdx_q) : wrData_q;
  wire [7:0] memRdData;

  conv_func_mem funcMem (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(memWe),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddr(funcIndex(addr_q)),
    .rdData_q(memRdData)
  );

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  reg [7:0] rdByte;

  // unmapped addresses read as zero
  always @* begin
    rdByte = 8'h00;
    if (addr_q == `ADDR_PORT_SETUP) begin
      rdByte = portSetup_q;
    end else if (addr_q == `ADDR_PART_ID) begin
      rdByte = PART_ID;
    end else if (addr_q == `ADDR_SPEED_GRADE) begin
      rdByte[`VARIANT_HI:`VARIANT_LO] = VARIANT_CODE;
    end else if (addr_q == `ADDR_COMMIT) begin
      rdByte[`BIT_COMMIT] = commit_q;
    end else if (isFunc(addr_q)) begin
      rdByte = memRdData;
    end
  end

  // ----------------------------------------------------------------
  // serial frame engine
  // ----------------------------------------------------------------
  // a raised select between whole bytes of a counted transfer only
  // stalls it; anywhere else the frame is dropped
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instrPhase_q <= 1'b1;
      bitCnt_q <= 4'h0;
      shiftIn_q <= 16'h0000;
      isRead_q <= 1'b0;
      streaming_q <= 1'b0;
      bytesLeft_q <= 2'h0;
      addr_q <= 13'h0000;
      txShift_q <= 8'h00;
      sdioOut_q <= 1'b0;
      sdioOutEnN_q <= 1'b1;
      wrReq_q <= 1'b0;
      wrAddr_q <= 13'h0000;
      wrData_q <= 8'h00;
    end else begin
      wrReq_q <= 1'b0;
      if (initBusy_q) begin
        // host traffic is ignored while defaults load
        instrPhase_q <= 1'b1;
        bitCnt_q <= 4'h0;
        sdioOutEnN_q <= 1'b1;
      end else if (csHigh) begin
        sdioOutEnN_q <= 1'b1;
        if (instrPhase_q || bitCnt_q != 4'h0 || streaming_q) begin
          instrPhase_q <= 1'b1;
          bitCnt_q <= 4'h0;
        end
      end else if (sclkRise) begin
        shiftIn_q <= shiftNext;
        if (instrPhase_q) begin
          if (bitCnt_q == `INSTR_LAST_BIT) begin
            // instruction: direction, byte count, address
            isRead_q <= instrWord[`INSTR_READ];
            bytesLeft_q <= instrWord[`INSTR_COUNT_HI:`INSTR_COUNT_LO];
            streaming_q <= &instrWord[`INSTR_COUNT_HI:`INSTR_COUNT_LO];
            addr_q <= instrWord[12:0];
            instrPhase_q <= 1'b0;
            bitCnt_q <= 4'h0;
          end else begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end
        end else if (bitCnt_q == `BYTE_LAST_BIT) begin
          bitCnt_q <= 4'h0;
          wrReq_q <= ~isRead_q;
          wrAddr_q <= addr_q;
          wrData_q <= rxByte;
          // walk down when msb first, up when lsb first
          addr_q <= addrNext;
          if (!streaming_q) begin
            if (bytesLeft_q == 2'h0) begin
              instrPhase_q <= 1'b1;
            end else begin
              bytesLeft_q <= bytesLeft_q - 2'h1;
            end
          end
        end else begin
          bitCnt_q <= bitCnt_q + 4'h1;
        end
      end else if (sclkFall) begin
        if (!instrPhase_q && isRead_q) begin
          sdioOutEnN_q <= 1'b0;
          if (bitCnt_q == 4'h0) begin
            txShift_q <= rdByte;
            sdioOut_q <= lsbFirst ? rdByte[0] : rdByte[7];
          end else if (lsbFirst) begin
            txShift_q <= {1'b0, txShift_q[7:1]};
            sdioOut_q <= txShift_q[1];
          end else begin
            txShift_q <= {txShift_q[6:0], 1'b0};
            sdioOut_q <= txShift_q[6];
          end
        end else begin
          sdioOutEnN_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes, soft reset and commit
  // ----------------------------------------------------------------
  wire wrSetup = wrReq_q && (wrAddr_q == `ADDR_PORT_SETUP);
  wire wrCommit = wrReq_q && (wrAddr_q == `ADDR_COMMIT) &&
                  wrData_q[`BIT_COMMIT];
  wire softReset = wrSetup && wrData_q[`BIT_SOFT_RESET];
  // identifier and grade addresses take no write at all

  // only bits 6 and 5 are writable; 4 and 3 stay one, the rest zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portSetup_q <= `RST_PORT_SETUP;
      commit_q <= 1'b0;
      analogStaged_q <= `RST_ANALOG_IN;
      analogInputActive_q <= `RST_ANALOG_IN;
      initBusy_q <= 1'b1;
      initIdx_q <= 8'h00;
    end else if (softReset) begin
      // defaults reload; bit 5 reads one until that completes
      portSetup_q <= `RST_PORT_SETUP;
      portSetup_q[`BIT_SOFT_RESET] <= 1'b1;
      commit_q <= 1'b0;
      analogStaged_q <= `RST_ANALOG_IN;
      analogInputActive_q <= `RST_ANALOG_IN;
      initBusy_q <= 1'b1;
      initIdx_q <= 8'h00;
    end else begin
      if (initBusy_q) begin
        // one memory location per cycle
        initIdx_q <= initIdx_q + 8'h01;
        if (initIdx_q == `FUNC_LAST_INDEX) begin
          initBusy_q <= 1'b0;
          portSetup_q[`BIT_SOFT_RESET] <= 1'b0;
        end
      end
      if (wrSetup) begin
        portSetup_q[`BIT_LSB_FIRST] <= wrData_q[`BIT_LSB_FIRST];
        portSetup_q[`BIT_FIXED_HI] <= 1'b1;
        portSetup_q[`BIT_FIXED_LO] <= 1'b1;
      end
      if (wrReq_q && wrAddr_q == `ADDR_ANALOG_IN) begin
        analogStaged_q <= wrData_q;
      end
      // a new commit write wins over the clear of the previous one
      commit_q <= wrCommit;
      if (commit_q) begin
        // staged value becomes active; bit 2 turns the buffer off
        analogInputActive_q <= analogStaged_q;
      end
    end
  end

endmodule

// *** converter_config_register_map_props.sv ***
/* assertions on the register bank ports.
   assumes one clock domain and a bind onto the top module. */
`timescale 1ns/1ps
module converter_config_register_map_props (
  input logic clk,
  input logic rst_n,
  input logic sclk,
  input logic chipSelectN,
  input logic sdioIn,
  input logic sdioOut_q,
  input logic sdioOutEnN_q,
  input logic [7:0] analogInputActive_q,
  input logic initBusy_q
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // select idle long enough for the synchroniser to see it
  sequence selIdle;
    chipSelectN [*5];
  endsequence
  sequence drvStart;
    $fell(sdioOutEnN_q);
  endsequence
  a_fill_after_reset: assert property (
    $rose(rst_n) |-> initBusy_q [*8])
    else $error("fill not held after reset");
  a_quiet_while_busy: assert property (initBusy_q |-> sdioOutEnN_q)
    else $error("pin driven during fill");
  a_analog_default: assert property (
    $rose(rst_n) |-> !analogInputActive_q)
    else $error("analog input not cleared");
  a_release_idle: assert property (selIdle |-> sdioOutEnN_q)
    else $error("pin driven while deselected");
  a_release_deselect: assert property (
    $rose(chipSelectN) |-> ##[1:6] sdioOutEnN_q)
    else $error("pin not released");
  a_drive_low_phase: assert property (
    drvStart |-> !sclk && !chipSelectN)
    else $error("drive starts off the low phase");
  a_bit_low_phase: assert property ($changed(sdioOut_q) |-> !sclk)
    else $error("read bit moved while clock high");
  a_active_in_frame: assert property (
    $changed(analogInputActive_q) |-> !chipSelectN)
    else $error("active copy moved outside a frame");
  a_soft_fill: assert property ($rose(initBusy_q) |-> !chipSelectN)
    else $error("fill started without a write");
endmodule
bind converter_config_register_map converter_config_register_map_props chk_u (
  .clk(clk), .rst_n(rst_n), .sclk(sclk), .chipSelectN(chipSelectN),
  .sdioIn(sdioIn), .sdioOut_q(sdioOut_q), .sdioOutEnN_q(sdioOutEnN_q),
  .analogInputActive_q(analogInputActive_q), .initBusy_q(initBusy_q));

// *** spi_host_model.sv ***
/* serial host model for the three-wire port.
   assumes the bench clock; resolves the shared data wire. */
`timescale 1ns/1ps
module spi_host_model (
  input logic clk,
  input logic sdioOut,
  input logic sdioOutEnN,
  output logic sclk,
  output logic chipSelectN,
  output logic sdioIn
);
  // ----
  // frame driver
  // ----
  localparam int HALF = 8; // wide phases leave sync margin
  logic hostBit;
  // device owns the wire while its enable is low
  assign sdioIn = sdioOutEnN ? hostBit : sdioOut;
  initial begin
    sclk = 1'b0;
    chipSelectN = 1'b1;
    hostBit = 1'b0;
  end
  // data set on the low phase, taken on the rise
  task automatic bitx(input logic b, output logic r);
    @(posedge clk);
    #1 sclk = 1'b0;
    hostBit = b;
    repeat (HALF) @(posedge clk);
    r = sdioIn;
    #1 sclk = 1'b1;
    repeat (HALF - 1) @(posedge clk);
  endtask
  // instruction then one byte; lsb reverses both
  task automatic xfer(input logic [15:0] ins, input logic [7:0] wd,
                      input logic lsb, output logic [7:0] rd);
    logic r;
    @(posedge clk);
    #1 chipSelectN = 1'b0;
    for (int i = 0; i < 16; i++) bitx(ins[lsb ? i : 15 - i], r);
    for (int i = 0; i < 8; i++) begin
      bitx(wd[lsb ? i : 7 - i], r);
      rd[lsb ? i : 7 - i] = r;
    end
    repeat (HALF) @(posedge clk);
    #1 sclk = 1'b0;
    repeat (HALF) @(posedge clk);
    #1 chipSelectN = 1'b1;
    hostBit = ~hostBit; // idle wire must not echo the last bit
  endtask
  // msb first instruction then two bytes; stall lifts select between
  // them, and a stream is ended by the select alone
  task automatic xfer2(input logic [15:0] ins, input logic [15:0] wd,
                       input logic stall, output logic [15:0] rd);
    logic r;
    @(posedge clk);
    #1 chipSelectN = 1'b0;
    for (int i = 0; i < 16; i++) bitx(ins[15 - i], r);
    for (int i = 0; i < 16; i++) begin
      if (stall && i == 8) begin
        repeat (HALF) @(posedge clk);
        #1 chipSelectN = 1'b1;
        repeat (HALF) @(posedge clk);
        #1 chipSelectN = 1'b0;
      end
      bitx(wd[15 - i], r);
      rd[15 - i] = r;
    end
    repeat (HALF) @(posedge clk);
    #1 sclk = 1'b0;
    repeat (HALF) @(posedge clk);
    #1 chipSelectN = 1'b1;
    hostBit = ~hostBit;
  endtask
endmodule

// *** converter_config_register_map_tb.sv ***
/* self-checking bench for the register bank.
   assumes the host model and checker are compiled first. */
`timescale 1ns/1ps
module converter_config_register_map_tb;
  localparam logic [7:0] PID = 8'h6B; // arbitrary value
  localparam logic [2:0] VAR = 3'h6; // arbitrary value
  localparam int LIMIT = 40000; // run needs about 10000
  logic clk, rst_n, sclk, chipSelectN, sdioIn, sdioOut_q, sdioOutEnN_q;
  logic initBusy_q;
  logic [7:0] analogInputActive_q, rd;
  int errTotal = 0;
  int testsRun = 0;
  int cycles = 0;
  // ----
  // structure
  // ----
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  converter_config_register_map #(.PART_ID(PID), .VARIANT_CODE(VAR)) dut_u (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .chipSelectN(chipSelectN),
    .sdioIn(sdioIn), .sdioOut_q(sdioOut_q), .sdioOutEnN_q(sdioOutEnN_q),
    .analogInputActive_q(analogInputActive_q), .initBusy_q(initBusy_q));
  spi_host_model host_u (.clk(clk), .sdioOut(sdioOut_q),
    .sdioOutEnN(sdioOutEnN_q), .sclk(sclk), .chipSelectN(chipSelectN),
    .sdioIn(sdioIn));
  // ----
  // helpers
  // ----
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    testsRun++;
    if (g !== e) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic l);
    host_u.xfer({3'h0, a}, d, l, rd);
  endtask
  task automatic rdr(input logic [12:0] a, input logic l);
    host_u.xfer({3'h4, a}, 8'h00, l, rd);
  endtask
  task automatic waitFill();
    for (int n = 0; n < 400 && initBusy_q !== 1'b0; n++) @(posedge clk);
    chk("busy", 8'h00, {7'h00, initBusy_q});
  endtask
  task automatic conclude();
    if (errTotal == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    chk("busy", 8'h01, {7'h00, initBusy_q});
    waitFill();
    chk("active", 8'h00, analogInputActive_q);
  endtask
  // read-only and unmapped writes must leave nothing behind
  task automatic t_ids();
    logic [12:0] adr [7];
    logic [7:0] val [7];
    adr = '{13'h0000, 13'h0001, 13'h0002, 13'h00FF, 13'h0014, 13'h0005,
            13'h0107};
    val = '{8'h18, PID, {1'h0, VAR, 4'h0}, 8'h00, 8'h08, 8'h00, 8'h00};
    wr(13'h0001, 8'h00, 1'b0);
    wr(13'h0002, 8'h00, 1'b0);
    wr(13'h0005, 8'h00, 1'b0);
    foreach (adr[i]) begin
      rdr(adr[i], 1'b0);
      chk("read", val[i], rd);
    end
  endtask
  task automatic t_commit();
    wr(13'h002C, 8'h04, 1'b0);
    chk("active", 8'h00, analogInputActive_q);
    rdr(13'h002C, 1'b0);
    chk("staged", 8'h04, rd);
    wr(13'h00FF, 8'h01, 1'b0);
    chk("active", 8'h04, analogInputActive_q);
    rdr(13'h00FF, 1'b0);
    chk("commit", 8'h00, rd);
  endtask
  task automatic t_lsb();
    wr(13'h0000, 8'h5A, 1'b0);
    rdr(13'h0000, 1'b1);
    chk("setup", 8'h58, rd);
    rdr(13'h0001, 1'b1);
    chk("part", PID, rd);
    wr(13'h0000, 8'h18, 1'b1);
    rdr(13'h0000, 1'b0);
    chk("setup", 8'h18, rd);
  endtask
  // two counted bytes with a stall, read back as a stream; msb first
  // walks the address down from 0x10 to 0x0F
  task automatic t_multi();
    logic [15:0] rd2;
    host_u.xfer2({3'h1, 13'h0010}, 16'h7E04, 1'b1, rd2);
    host_u.xfer2({3'h7, 13'h0010}, 16'h0000, 1'b0, rd2);
    chk("stream hi", 8'h7E, rd2[15:8]);
    chk("stream lo", 8'h04, rd2[7:0]);
  endtask
  task automatic t_soft();
    wr(13'h0000, 8'h3C, 1'b0);
    chk("fill", 8'h01, {7'h00, initBusy_q});
    waitFill();
    chk("active", 8'h00, analogInputActive_q);
    rdr(13'h0000, 1'b0);
    chk("setup", 8'h18, rd);
  endtask
  // ----
  // sequence and watchdog
  // ----
  initial begin
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_ids();
    t_commit();
    t_lsb();
    t_multi();
    t_soft();
    conclude();
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errTotal = errTotal + 1;
      conclude();
    end
  end
endmodule
